// ===== verilog/wtw_pkg.sv
// Constants for the wake timer watchdog: timing in oscillator ticks,
// state encoding and the interval selection code layout.
// Assumes a 40 MHz core clock that stands in for the low-frequency oscillator.
package wtw_pkg;

    localparam int CNT_W = 20;
    localparam int CODE_W = 11;

    // Core clock and internal oscillator
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_PERIOD_NS = 10_000_000;
    localparam int TICK_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_PERIOD_MS = 10;

    // Times in milliseconds, as specified
    localparam int STROBE_MS = 20;
    localparam int ACK_MARGIN_MS = 20;
    localparam int RESET_PULSE_WIDTH_MS = 320;
    localparam int DEBOUNCE_TIME_MS = 20;
    localparam int CONVERSION_MAX_MS = 120;
    localparam int STEP_MS = 100;
    localparam int SEC_MS = 1000;

    // Same times in oscillator ticks
    localparam logic [CNT_W-1:0] STROBE_TICKS = CNT_W'(STROBE_MS / OSC_PERIOD_MS);
    localparam logic [CNT_W-1:0] ACK_MARGIN_TICKS = CNT_W'(ACK_MARGIN_MS / OSC_PERIOD_MS);
    localparam logic [CNT_W-1:0] RST_TICKS = CNT_W'(RESET_PULSE_WIDTH_MS / OSC_PERIOD_MS);
    localparam logic [CNT_W-1:0] DEBOUNCE_TICKS = CNT_W'(DEBOUNCE_TIME_MS / OSC_PERIOD_MS);
    localparam logic [CNT_W-1:0] CONV_TICKS = CNT_W'(CONVERSION_MAX_MS / OSC_PERIOD_MS);
    localparam logic [CNT_W-1:0] STEP_TICKS = CNT_W'(STEP_MS / OSC_PERIOD_MS);
    localparam logic [CNT_W-1:0] SEC_TICKS = CNT_W'(SEC_MS / OSC_PERIOD_MS);

    // Interval selection code: 1629 distinct intervals, codes 0 to 1628; higher codes saturate
    localparam logic [CODE_W-1:0] FINE_CODES = 11'h0009;
    localparam logic [CODE_W-1:0] LIN_LAST_CODE = 11'h03F0;
    localparam logic [CNT_W-1:0] LIN_LAST_S = 20'h0_03E8;
    localparam logic [CNT_W-1:0] COARSE_STEP_S = 20'h0_000A;
    localparam logic [CNT_W-1:0] MAX_S = 20'h0_1C20;

    typedef enum logic [5:0] {
        ST_RWAIT = 6'b00_0001,
        ST_READ = 6'b00_0010,
        ST_RUN = 6'b00_0100,
        ST_RPULSE = 6'b00_1000,
        ST_MHOLD = 6'b01_0000,
        ST_MDEB = 6'b10_0000
    } wtw_state_t;

endpackage

// ===== verilog/wtw_top.sv
// Wake timer watchdog: periodic strobe to a sleeping host, acknowledge
// supervision, manual reset debounce and one-time interval selection.
// Assumes all inputs are synchronous to core_clk and an external converter
// measures the selection resistor while meas_path_en is high.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1: Strobe fires at each interval start; rising edges spaced by selected interval.
// RULE2: Host acknowledges each strobe at least 20 ms before the next one.
// RULE3: Missing acknowledge by that deadline asserts host reset at new interval.
// RULE4: No strobe at first interval start or after an unacknowledged interval.
// RULE5: Strobe output rests low between pulses.
// RULE6: Only a rising edge on the acknowledge input counts.
// RULE7: Only the first acknowledge edge per interval is acted upon.
// RULE8: Acknowledge clears the watchdog only; interval timing continues.
// RULE9: Acknowledge during a strobe pulse ends that pulse at once.
// RULE10: Host waits 100 ns to interval minus 20 ms before acknowledging.
// RULE11: Host reset is low during power-on reset and resistor reading.
// RULE12: Manual reset needs two consecutive high oscillator samples.
// RULE13: Resistor is read once after power-on; selection latched thereafter.
// RULE14: Manual reset during reading aborts it; reading restarts after release.
// RULE15: Manual reset clears counters; restart after release plus reset pulse width.
// RULE16: Manual reset asserts host reset after recognition, held through debounce and pulse.
// RULE17: Manual reset forces strobe low and host reset asserted.
// RULE18: Timeout or manual reset asserts host reset and restarts counters.
// RULE19: Reset release to next release or strobe equals interval plus pulse width; the code gives release to next strobe as the interval alone.
// RULE20: Interval spans 100 ms to 7200 s.
// RULE21: After reading, measurement path is off and pin feeds reset detector.
// RULE22: Pin tied high counts as manual reset; interval stays unprogrammed.
// RULE23: Resistor conversion takes at most 120 ms.
// RULE24: 1650 selections: nine 100 ms steps, the rest 1 s to 7200 s; code decodes 1629 (codes 0 to 1628).
// RULE25: Lowest nine selections are exact multiples of 100 ms.
// RULE26: Strobe and reset pulse widths are fixed oscillator-tick counts.
// RULE27: Interval starts only after a valid code and host reset release.
module wtw_top #(
    parameter int TICK_CYCLES = wtw_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic mrst_pin,
    input wire logic ack_in,
    input wire logic conv_done,
    input wire logic [wtw_pkg::CODE_W-1:0] conv_code,
    input wire logic host_reset_n_in,
    output logic host_reset_n_out,
    output logic host_reset_n_oe_n,
    output logic strobe,
    output logic meas_path_en,
    output logic conv_start,
    output logic wd_pin_level
);

    // Maps a converter code to an interval length in ticks
    function automatic logic [wtw_pkg::CNT_W-1:0] sel_to_ticks(
        input logic [wtw_pkg::CODE_W-1:0] code
    );
        logic [wtw_pkg::CNT_W-1:0] c;
        logic [wtw_pkg::CNT_W-1:0] secs;
        c = wtw_pkg::CNT_W'(code);
        secs = wtw_pkg::MAX_S;
        if (code < wtw_pkg::FINE_CODES)
        begin
            sel_to_ticks = wtw_pkg::CNT_W'((c + 20'h0_0001) * wtw_pkg::STEP_TICKS); // RULE25
        end
        else
        begin
            if (code <= wtw_pkg::LIN_LAST_CODE)
            begin
                secs = c - wtw_pkg::CNT_W'(wtw_pkg::FINE_CODES) + 20'h0_0001;
            end
            else
            begin
                secs = wtw_pkg::LIN_LAST_S + wtw_pkg::CNT_W'((c - wtw_pkg::CNT_W'(wtw_pkg::LIN_LAST_CODE))
                    * wtw_pkg::COARSE_STEP_S);
                if (secs > wtw_pkg::MAX_S)
                begin
                    secs = wtw_pkg::MAX_S; // RULE20
                end
            end
            sel_to_ticks = wtw_pkg::CNT_W'(secs * wtw_pkg::SEC_TICKS); // RULE24
        end
    endfunction

    localparam logic [wtw_pkg::CNT_W-1:0] TICK_LAST = wtw_pkg::CNT_W'(TICK_CYCLES - 1);

    wtw_pkg::wtw_state_t st_r;
    logic [wtw_pkg::CNT_W-1:0] tick_cnt_r;
    logic tick;
    logic mrst_s_r;
    logic mrst_valid;
    logic [wtw_pkg::CNT_W-1:0] cnt_r;
    logic [wtw_pkg::CNT_W-1:0] interval_r;
    logic [wtw_pkg::CNT_W-1:0] strobe_left_r;
    logic strobe_r;
    logic ack_d_r;
    logic ack_seen_r;
    logic ack_edge;
    logic ack_valid;
    logic boundary;
    logic oe_n_r;
    logic meas_r;
    logic start_r;
    logic pin_r;

    assign tick = (tick_cnt_r == TICK_LAST);
    // Two consecutive high samples, only once the pin feeds the detector
    assign mrst_valid = tick && mrst_pin && mrst_s_r; // RULE12
    assign boundary = (st_r == wtw_pkg::ST_RUN) && tick && (cnt_r == interval_r - 20'h0_0001);
    assign ack_edge = ack_in && !ack_d_r; // RULE6
    // Late edges and repeats are dropped; a boundary edge belongs to the next interval
    assign ack_valid = ack_edge && (st_r == wtw_pkg::ST_RUN) && (!ack_seen_r || boundary) // RULE7
        && (boundary || (cnt_r < interval_r - wtw_pkg::ACK_MARGIN_TICKS)); // RULE3

    // Oscillator tick prescaler; free running so debounce sampling never stops
    always_ff @(posedge core_clk)
    begin
        if (rst || tick)
        begin
            tick_cnt_r <= '0;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 20'h0_0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mrst_s_r <= 1'b0;
            ack_d_r <= 1'b0;
            pin_r <= 1'b1;
        end
        else
        begin
            if (tick)
            begin
                mrst_s_r <= mrst_pin;
            end
            ack_d_r <= ack_in;
            pin_r <= host_reset_n_in;
        end
    end
    // Main sequencer and shared counter
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r <= wtw_pkg::ST_RWAIT;
            cnt_r <= '0;
            start_r <= 1'b0;
        end
        else
        begin
            start_r <= 1'b0;
            case (st_r)
                wtw_pkg::ST_RWAIT:
                begin
                    cnt_r <= '0;
                    if (tick && !mrst_pin) // RULE14
                    begin
                        st_r <= wtw_pkg::ST_READ;
                        start_r <= 1'b1;
                    end
                end
                wtw_pkg::ST_READ:
                begin
                    if (conv_done)
                    begin
                        st_r <= wtw_pkg::ST_RUN; // RULE27
                        cnt_r <= '0;
                    end
                    else if (tick && mrst_pin)
                    begin
                        st_r <= wtw_pkg::ST_RWAIT; // RULE14 RULE22
                    end
                    else if (tick && cnt_r == wtw_pkg::CONV_TICKS - 20'h0_0001)
                    begin
                        cnt_r <= '0; // RULE23
                        start_r <= 1'b1;
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r + 20'h0_0001;
                    end
                end
                wtw_pkg::ST_RUN:
                begin
                    if (mrst_valid)
                    begin
                        st_r <= wtw_pkg::ST_MHOLD; // RULE15 RULE18
                        cnt_r <= '0;
                    end
                    else if (boundary)
                    begin
                        cnt_r <= '0; // RULE1 RULE19
                        if (!ack_seen_r)
                        begin
                            st_r <= wtw_pkg::ST_RPULSE; // RULE3 RULE18
                        end
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r + 20'h0_0001; // RULE8
                    end
                end
                wtw_pkg::ST_RPULSE:
                begin
                    if (mrst_valid)
                    begin
                        st_r <= wtw_pkg::ST_MHOLD;
                        cnt_r <= '0;
                    end
                    else if (tick && cnt_r == wtw_pkg::RST_TICKS - 20'h0_0001)
                    begin
                        st_r <= wtw_pkg::ST_RUN; // RULE19 RULE26
                        cnt_r <= '0;
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r + 20'h0_0001;
                    end
                end
                wtw_pkg::ST_MHOLD:
                begin
                    cnt_r <= '0;
                    if (tick && !mrst_pin)
                    begin
                        st_r <= wtw_pkg::ST_MDEB;
                    end
                end
                wtw_pkg::ST_MDEB:
                begin
                    if (tick && mrst_pin)
                    begin
                        st_r <= wtw_pkg::ST_MHOLD;
                        cnt_r <= '0;
                    end
                    else if (tick && cnt_r == wtw_pkg::DEBOUNCE_TICKS - 20'h0_0001)
                    begin
                        st_r <= wtw_pkg::ST_RPULSE; // RULE15 RULE16
                        cnt_r <= '0;
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r + 20'h0_0001;
                    end
                end
                default:
                begin
                    st_r <= wtw_pkg::ST_RWAIT;
                    cnt_r <= '0;
                end
            endcase
        end
    end
    // Selection is latched only from the single successful reading
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            interval_r <= wtw_pkg::STEP_TICKS;
        end
        else if (st_r == wtw_pkg::ST_READ && conv_done)
        begin
            interval_r <= sel_to_ticks(conv_code); // RULE13
        end
    end
    // Watchdog flag; a new edge wins over the interval clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ack_seen_r <= 1'b0;
        end
        else if (ack_valid)
        begin
            ack_seen_r <= 1'b1; // RULE8
        end
        else if (boundary || st_r != wtw_pkg::ST_RUN)
        begin
            ack_seen_r <= 1'b0;
        end
    end
    // Strobe pulse
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            strobe_r <= 1'b0;
            strobe_left_r <= '0;
        end
        else if (mrst_valid || st_r != wtw_pkg::ST_RUN)
        begin
            strobe_r <= 1'b0; // RULE17 RULE5
            strobe_left_r <= '0;
        end
        else if (boundary && ack_seen_r)
        begin
            strobe_r <= 1'b1; // RULE1 RULE4
            strobe_left_r <= wtw_pkg::STROBE_TICKS; // RULE26
        end
        else if (strobe_r && ack_valid)
        begin
            strobe_r <= 1'b0; // RULE9
            strobe_left_r <= '0;
        end
        else if (strobe_r && tick)
        begin
            if (strobe_left_r == 20'h0_0001)
            begin
                strobe_r <= 1'b0; // RULE5
            end
            strobe_left_r <= strobe_left_r - 20'h0_0001;
        end
    end
    // Host reset and measurement path
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            oe_n_r <= 1'b0; // RULE11
            meas_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                wtw_pkg::ST_RUN:
                begin
                    oe_n_r <= !(mrst_valid || (boundary && !ack_seen_r)); // RULE3 RULE16 RULE17
                    meas_r <= 1'b0; // RULE21
                end
                wtw_pkg::ST_READ:
                begin
                    oe_n_r <= conv_done;
                    meas_r <= !conv_done && !(tick && mrst_pin); // RULE11 RULE21
                end
                wtw_pkg::ST_RPULSE:
                begin
                    oe_n_r <= tick && !mrst_valid && cnt_r == wtw_pkg::RST_TICKS - 20'h0_0001;
                    meas_r <= 1'b0;
                end
                wtw_pkg::ST_RWAIT:
                begin
                    oe_n_r <= 1'b0;
                    meas_r <= tick && !mrst_pin;
                end
                default:
                begin
                    oe_n_r <= 1'b0;
                    meas_r <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain: only ever pulls low
    assign host_reset_n_out = 1'b0;
    assign host_reset_n_oe_n = oe_n_r;
    assign strobe = strobe_r;
    assign meas_path_en = meas_r;
    assign conv_start = start_r;
    assign wd_pin_level = pin_r;

endmodule

`default_nettype wire

// ===== sim/wtw_host_model.sv
// Host model: one acknowledge pulse after each strobe rise or reset release.
// Assumes ack_delay in core cycles; zero keeps the host silent.
`timescale 1ns/10ps
`default_nettype none
module wtw_host_model (
    input wire logic core_clk,
    input wire logic strobe,
    input wire logic host_reset_n,
    input wire logic [7:0] ack_delay,
    output logic ack_in
);
    logic strobe_d;
    logic reset_d;
    logic [8:0] wait_r;

    initial ack_in = 1'b0;
    initial wait_r = 9'h000;

    always @(posedge core_clk)
    begin
        strobe_d <= strobe;
        reset_d <= host_reset_n;
        if ((strobe && !strobe_d) || (host_reset_n && !reset_d))
            wait_r <= {1'b0, ack_delay};
        else if (wait_r != 9'h000)
            wait_r <= wait_r - 9'h001;
        // Held in reset the host says nothing
        ack_in <= host_reset_n && (wait_r == 9'h001 || wait_r == 9'h002);
    end
endmodule
`default_nettype wire

// ===== sim/wtw_chk.sv
// Assertion checker on the wake timer watchdog top ports.
// Assumes a bind from the bench; spacing is checked for the 100 ms codes only.
`timescale 1ns/10ps
`default_nettype none
module wtw_chk #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic mrst_pin,
    input wire logic ack_in,
    input wire logic conv_done,
    input wire logic [wtw_pkg::CODE_W-1:0] conv_code,
    input wire logic host_reset_n_in,
    input wire logic host_reset_n_out,
    input wire logic host_reset_n_oe_n,
    input wire logic strobe,
    input wire logic meas_path_en,
    input wire logic conv_start,
    input wire logic wd_pin_level
);
    logic strobe_d;
    logic oe_d;
    logic gap_ok;
    logic rel_ok;
    logic mr_flag;
    logic code_v;
    logic [wtw_pkg::CODE_W-1:0] code_r;
    logic [31:0] gap_cnt;
    logic [31:0] rel_cnt;
    logic [31:0] low_cnt;
    logic [31:0] hi_cnt;
    logic [31:0] period;
    logic [31:0] tk;
    logic str_rise;
    logic oe_rise;

    assign str_rise = strobe && !strobe_d;
    assign oe_rise = host_reset_n_oe_n && !oe_d;
    assign tk = 32'(TICK_CYCLES);
    assign period = (32'(code_r) + 32'h0000_0001) * 32'h0000_000A * tk;

    always_ff @(posedge core_clk)
    begin
        strobe_d <= strobe;
        oe_d <= host_reset_n_oe_n;
        gap_cnt <= str_rise ? 32'h0000_0001 : gap_cnt + 32'h0000_0001;
        rel_cnt <= oe_rise ? 32'h0000_0001 : rel_cnt + 32'h0000_0001;
        low_cnt <= host_reset_n_oe_n ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
        hi_cnt <= mrst_pin ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
    end

    // Any reset breaks the spacing chain; pin activity marks a manual release
    always_ff @(posedge core_clk)
    begin
        if (rst || !host_reset_n_oe_n)
            gap_ok <= 1'b0;
        else if (str_rise)
            gap_ok <= 1'b1;
        if (rst || !host_reset_n_oe_n || str_rise)
            rel_ok <= 1'b0;
        else if (oe_rise)
            rel_ok <= 1'b1;
        if (rst || mrst_pin)
            mr_flag <= 1'b1;
        else if (oe_rise)
            mr_flag <= 1'b0;
        if (rst)
            code_v <= 1'b0;
        else if (meas_path_en && conv_done)
            code_v <= 1'b1;
        if (meas_path_en && conv_done && !code_v)
            code_r <= conv_code;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_rst_defaults: assert property (disable iff (1'b0)
        rst |=> !host_reset_n_oe_n && !strobe && !meas_path_en && !conv_start)
        else $error("outputs not at defaults after reset");
    a_meas_holds_reset: assert property (meas_path_en |-> !host_reset_n_oe_n)
        else $error("host reset released while reading");
    a_start_then_meas: assert property (conv_start && !mrst_pin |=> meas_path_en)
        else $error("reading path not opened after start");
    a_done_releases: assert property (meas_path_en && conv_done && !mrst_pin
        |=> host_reset_n_oe_n && !meas_path_en)
        else $error("reading not closed on converter done");
    a_strobe_spacing: assert property (str_rise && gap_ok && code_v && code_r < wtw_pkg::FINE_CODES
        |-> gap_cnt == period)
        else $error("strobe spacing differs from interval");
    a_release_gap: assert property (str_rise && rel_ok && code_v && code_r < wtw_pkg::FINE_CODES
        |-> rel_cnt > period - tk && rel_cnt <= period + tk)
        else $error("first strobe after release off interval");
    a_wd_pulse_width: assert property (oe_rise && !mr_flag |-> low_cnt == 32 * tk)
        else $error("watchdog reset pulse width wrong");
    a_manual_forces: assert property (hi_cnt > 3 * tk + 1 |-> !host_reset_n_oe_n && !strobe)
        else $error("held manual reset not forcing outputs");
    a_ack_cuts_strobe: assert property (strobe && ack_in && !$past(ack_in) |-> ##[1:2] !strobe)
        else $error("strobe not ended by acknowledge");
    a_pin_echo: assert property (!$past(rst) |-> wd_pin_level == $past(host_reset_n_in))
        else $error("reset line level not reported");

    c_strobe: cover property (str_rise && gap_ok);
    c_watchdog: cover property (oe_rise && !mr_flag);
    c_ack_cut: cover property (strobe && ack_in && !$past(ack_in));
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Bench for the wake timer watchdog: interval table, then watchdog, manual reset and reading abort.
// Assumes one 10 ms tick is shortened to four core cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int T = 4;
    logic core_clk;
    logic rst;
    logic mrst_pin;
    logic ack_in;
    logic host_ack;
    logic tb_ack;
    logic conv_done;
    logic [wtw_pkg::CODE_W-1:0] conv_code;
    logic reset_line_n;
    logic host_reset_n_out;
    logic host_reset_n_oe_n;
    logic strobe;
    logic meas_path_en;
    logic conv_start;
    logic [7:0] ack_delay;
    int cyc = 0;
    int n_strobe = 0;
    int n_fail = 0;
    int comparisons = 0;
    // Code, host ack delay in cycles, interval in ms
    int rows[5][3] = '{'{0, 12, 100}, '{4, 30, 500}, '{8, 5, 900}, '{9, 100, 1000}, '{10, 200, 2000}};

    assign ack_in = host_ack | tb_ack;
    // Pull-up on the open-drain reset line
    assign reset_line_n = host_reset_n_oe_n ? 1'b1 : host_reset_n_out;

    wtw_top #(.TICK_CYCLES(T)) uut (.core_clk(core_clk), .rst(rst), .mrst_pin(mrst_pin), .ack_in(ack_in),
        .conv_done(conv_done), .conv_code(conv_code), .host_reset_n_in(reset_line_n),
        .host_reset_n_out(host_reset_n_out), .host_reset_n_oe_n(host_reset_n_oe_n), .strobe(strobe),
        .meas_path_en(meas_path_en), .conv_start(conv_start), .wd_pin_level());
    wtw_host_model host (.core_clk(core_clk), .strobe(strobe), .host_reset_n(reset_line_n),
        .ack_delay(ack_delay), .ack_in(host_ack));

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    always @(posedge strobe) n_strobe++;

    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Cycle stamp of the first edge showing the event, -1 if none within limit
    task automatic wait_ev(input int sel, input int limit, output int t);
        logic v;
        int n;
        n = 0;
        t = -1;
        while (n < limit && t < 0)
        begin
            @(posedge core_clk);
            #1;
            case (sel)
                0: v = strobe;
                1: v = !host_reset_n_oe_n;
                2: v = host_reset_n_oe_n;
                3: v = conv_start;
                default: v = !strobe;
            endcase
            if (v === 1'b1)
                t = cyc;
            n++;
        end
    endtask

    task automatic pulse_done(input logic [10:0] code);
        @(negedge core_clk);
        conv_code = code;
        conv_done = 1'b1;
        @(negedge core_clk);
        conv_done = 1'b0;
    endtask

    task automatic power_up(input logic [10:0] code);
        int t;
        @(negedge core_clk);
        rst = 1'b1;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        wait_ev(3, 200, t);
        check(t >= 0, "no conversion start");
        @(negedge core_clk);
        pulse_done(code);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        int t0, t1, t2, t3, per, n0;
        rst = 1'b1;
        mrst_pin = 1'b0;
        tb_ack = 1'b0;
        conv_done = 1'b0;
        conv_code = 11'h000;
        ack_delay = 8'h0C;
        for (int i = 0; i < 5; i++)
        begin
            ack_delay = 8'(rows[i][1]);
            power_up(11'(rows[i][0]));
            per = rows[i][2] / 10 * T;
            wait_ev(2, 100, t0);
            wait_ev(0, per + 2 * T, t1);
            check(t0 >= 0 && t1 - t0 > per - T && t1 - t0 <= per + T, "first strobe off interval");
            wait_ev(4, 20, t2);
            check(rows[i][1] > 8 ? t2 - t1 == 2 * T : t2 - t1 < 2 * T, "strobe width");
            pulse_done(11'h001);
            wait_ev(0, per + 2 * T, t3);
            check(t3 - t1 == per, "strobe spacing");
        end
        // Acknowledge after the deadline
        // Lands inside the last 20 ms of each interval, so the margin itself is tested
        ack_delay = 8'h22;
        power_up(11'h000);
        per = 10 * T;
        wait_ev(2, 100, t0);
        n0 = n_strobe;
        wait_ev(1, per + 2 * T, t1);
        wait_ev(2, 40 * T, t2);
        wait_ev(1, per + 2 * T, t3);
        check(t1 >= 0 && t3 >= 0 && n_strobe == n0, "late ack did not reset");
        check(t2 - t1 == 32 * T && t3 - t1 == 32 * T + per, "reset timing");
        // Acknowledge held high, never an edge
        ack_delay = 8'h00;
        @(negedge core_clk);
        tb_ack = 1'b1;
        power_up(11'h000);
        wait_ev(2, 100, t0);
        n0 = n_strobe;
        wait_ev(1, per + 2 * T, t1);
        check(t1 >= 0 && n_strobe == n0, "static ack level accepted");
        @(negedge core_clk);
        tb_ack = 1'b0;
        ack_delay = 8'h0C;
        power_up(11'h000);
        wait_ev(2, 100, t0);
        @(negedge core_clk);
        mrst_pin = 1'b1;
        repeat (T) @(negedge core_clk);
        mrst_pin = 1'b0;
        repeat (20) @(negedge core_clk);
        check(host_reset_n_oe_n === 1'b1, "glitch taken as manual reset");
        mrst_pin = 1'b1;
        repeat (40) @(negedge core_clk);
        check(host_reset_n_oe_n === 1'b0 && strobe === 1'b0, "manual reset not forcing defaults");
        mrst_pin = 1'b0;
        t0 = cyc;
        wait_ev(2, 40 * T, t1);
        check(t1 - t0 >= 34 * T && t1 - t0 <= 36 * T, "manual reset release time");
        wait_ev(0, per + 2 * T, t2);
        check(t2 - t1 == per, "no restart after manual reset");
        // Pin high across power-up, then an abort in mid-reading
        @(negedge core_clk);
        mrst_pin = 1'b1;
        rst = 1'b1;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        wait_ev(3, 60, t0);
        check(t0 < 0 && host_reset_n_oe_n === 1'b0, "reading started with pin high");
        @(negedge core_clk);
        mrst_pin = 1'b0;
        wait_ev(3, 20, t0);
        @(negedge core_clk);
        mrst_pin = 1'b1;
        repeat (3 * T) @(negedge core_clk);
        check(t0 >= 0 && meas_path_en === 1'b0 && host_reset_n_oe_n === 1'b0, "reading not aborted");
        mrst_pin = 1'b0;
        wait_ev(3, 20, t1);
        check(t1 >= 0, "reading not restarted");
        wait_ev(3, 60, t2);
        check(t1 >= 0 && t2 - t1 == wtw_pkg::CONVERSION_MAX_MS / 10 * T, "conversion not retried");
        print_verdict();
    end

    initial
    begin
        #(25 * 20000);
        n_fail++;
        $display("unexpected at %0t: run did not finish", $time);
        print_verdict();
    end
endmodule

bind wtw_top wtw_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.core_clk(core_clk), .rst(rst), .mrst_pin(mrst_pin),
    .ack_in(ack_in), .conv_done(conv_done), .conv_code(conv_code), .host_reset_n_in(host_reset_n_in),
    .host_reset_n_out(host_reset_n_out), .host_reset_n_oe_n(host_reset_n_oe_n), .strobe(strobe),
    .meas_path_en(meas_path_en), .conv_start(conv_start), .wd_pin_level(wd_pin_level));
`default_nettype wire
